// File: logic/backlight_cfg_defines.vh
// Register offsets, field positions, reset values and clock rate in MHz for the user configuration block
`ifndef BACKLIGHT_CFG_DEFINES_VH
`define BACKLIGHT_CFG_DEFINES_VH
`define ADDR_USER_CONFIGURATION_ONE 8'h04
`define ADDR_PWM_DUTY_DIAG          8'h16
`define RESET_USER_CONFIGURATION    16'h08A3
`define BIT_PSEUDO_EN               14
`define MSB_MOD_RATE                13
`define LSB_MOD_RATE                12
`define MSB_OSC_RANGE               11
`define LSB_OSC_RANGE               10
`define MSB_SOURCE                  9
`define LSB_SOURCE                  8
`define MSB_SLOPE                   7
`define LSB_SLOPE                   5
`define MSB_DITHER                  4
`define LSB_DITHER                  2
`define BIT_SMOOTH                  1
`define SOURCE_PWM_PIN              2'h0
`define SOURCE_REGISTER             2'h2
`define SLOPE_OFF                   3'h0
`define DITHER_MAX                  3'h4
`define CLK_MHZ                     250
`endif

// File: logic/backlight_user_config.v
// User configuration register with derived control outputs and PWM duty measurement
`timescale 1ns/1ns
`include "backlight_cfg_defines.vh"
module backlight_user_config
#(
    parameter DUTY_WIDTH = 16
)
(
    input  wire        CLK_SYS,
    input  wire        RESETN,
    input  wire [7:0]  REG_ADDR,
    input  wire        REG_WRITE,
    input  wire        REG_READ,
    input  wire [15:0] REG_WDATA,
    output reg  [15:0] REG_RDATA,
    input  wire        PWM_IN,
    output reg         PSEUDO_RANDOM_ENABLE,
    output reg  [1:0]  SPREAD_MODULATION_RATE,
    output reg  [1:0]  BOOST_OSCILLATOR_RANGE,
    output reg         BRIGHTNESS_FROM_REGISTER,
    output reg  [2:0]  SLOPE_DURATION,
    output reg         SLOPE_ENABLE,
    output reg  [2:0]  DITHER_BITS,
    output reg         SMOOTH_TRANSITION_ENABLE,
    output reg  [1:0]  SMOOTH_FILTER_SHIFT,
    output reg  [19:0] SLOPE_TIME_MS
);

////////////////////////////////////////////////////////////////////////////
reg  [15:0]             user_configuration_one;
reg                     pwm_meta;
reg                     pwm_sync;
reg                     pwm_last;
reg  [DUTY_WIDTH-1:0]   high_count;
reg  [DUTY_WIDTH-1:0]   period_count;
reg  [DUTY_WIDTH-1:0]   duty_value;
wire                    pin_source;
wire                    period_end;
wire [2:0]              slope_code;
wire [2:0]              dither_code;
wire                    smooth_sel;

// Base slope time in milliseconds for a duration code
function [9:0] slope_ms;
    input [2:0] code;
    begin
        case (code)
            3'h1:    slope_ms = 10'h001;
            3'h2:    slope_ms = 10'h002;
            3'h3:    slope_ms = 10'h032;
            3'h4:    slope_ms = 10'h064;
            3'h5:    slope_ms = 10'h0C8;
            3'h6:    slope_ms = 10'h12C;
            3'h7:    slope_ms = 10'h1F4;
            default: slope_ms = 10'h000;
        endcase
    end
endfunction

// Duty as a fraction of full scale, saturating at the top code
// Full-width quotient: a pin high for the whole period gives one past the top
function [DUTY_WIDTH-1:0] duty_ratio;
    input [DUTY_WIDTH-1:0]   high;
    input [DUTY_WIDTH-1:0]   period;
    reg   [2*DUTY_WIDTH-1:0] quotient;
    begin
        quotient = {high, {DUTY_WIDTH{1'b0}}} / {{DUTY_WIDTH{1'b0}}, period};
        if (quotient > {{DUTY_WIDTH{1'b0}}, {DUTY_WIDTH{1'b1}}})
            duty_ratio = {DUTY_WIDTH{1'b1}};
        else
            duty_ratio = quotient[DUTY_WIDTH-1:0];
    end
endfunction

////////////////////////////////////////////////////////////////////////////
// Register write; all bits including reserved ones are stored as written
always @(posedge CLK_SYS or negedge RESETN)
begin
    if (!RESETN)
        user_configuration_one <= `RESET_USER_CONFIGURATION;
    else if (REG_WRITE && REG_ADDR == `ADDR_USER_CONFIGURATION_ONE)
        user_configuration_one <= REG_WDATA;
end

// Register read port, registered so that the output is a flip-flop
// Unmapped offsets read as zero so a host scan never sees stale data
always @(posedge CLK_SYS or negedge RESETN)
begin
    if (!RESETN)
        REG_RDATA <= 16'h0000;
    else if (REG_READ)
    begin
        case (REG_ADDR)
            `ADDR_USER_CONFIGURATION_ONE: REG_RDATA <= user_configuration_one;
            `ADDR_PWM_DUTY_DIAG:          REG_RDATA <= duty_value;
            default:                      REG_RDATA <= 16'h0000;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////
// Decoded control outputs, one cycle behind the register
// Reset image equals the decode of the reset word, so nothing jumps at release
always @(posedge CLK_SYS or negedge RESETN)
begin
    if (!RESETN)
    begin
        PSEUDO_RANDOM_ENABLE     <= 1'b0;
        SPREAD_MODULATION_RATE   <= 2'h0;
        BOOST_OSCILLATOR_RANGE   <= 2'h2;
        BRIGHTNESS_FROM_REGISTER <= 1'b0;
        SLOPE_DURATION           <= 3'h5;
        SLOPE_ENABLE             <= 1'b1;
        DITHER_BITS              <= 3'h0;
        SMOOTH_TRANSITION_ENABLE <= 1'b1;
        SMOOTH_FILTER_SHIFT      <= 2'h2;
        SLOPE_TIME_MS            <= 20'h00190;
    end
    else
    begin
        PSEUDO_RANDOM_ENABLE   <= user_configuration_one[`BIT_PSEUDO_EN];
        SPREAD_MODULATION_RATE <= user_configuration_one[`MSB_MOD_RATE:`LSB_MOD_RATE];
        BOOST_OSCILLATOR_RANGE <= user_configuration_one[`MSB_OSC_RANGE:`LSB_OSC_RANGE];
        // source select; reserved codes fall back to the pin
        BRIGHTNESS_FROM_REGISTER <=
            (user_configuration_one[`MSB_SOURCE:`LSB_SOURCE] == `SOURCE_REGISTER);
        SLOPE_DURATION <= slope_code;
        SLOPE_ENABLE   <= (slope_code != `SLOPE_OFF);
        // dither depth, codes above four clamp to four
        DITHER_BITS <= (dither_code > `DITHER_MAX) ? `DITHER_MAX : dither_code;
        SMOOTH_TRANSITION_ENABLE <= smooth_sel;
        // smooth mode doubles time and adds filtering
        // Doubling stands in for the longer smooth ramp; the shift feeds the sloper filter
        SMOOTH_FILTER_SHIFT <= smooth_sel ? 2'h2 : 2'h0;
        SLOPE_TIME_MS <= smooth_sel ?
            {9'h000, slope_ms(slope_code), 1'b0} :
            {10'h000, slope_ms(slope_code)};
    end
end

////////////////////////////////////////////////////////////////////////////
// Pin synchroniser; the first stage feeds only the second, the second and third feed logic
always @(posedge CLK_SYS or negedge RESETN)
begin
    if (!RESETN)
    begin
        pwm_meta <= 1'b0;
        pwm_sync <= 1'b0;
        pwm_last <= 1'b0;
    end
    else
    begin
        pwm_meta <= PWM_IN;
        pwm_sync <= pwm_meta;
        pwm_last <= pwm_sync;
    end
end

// Measurement runs only for source code 0; reserved codes keep it idle
assign pin_source = (user_configuration_one[`MSB_SOURCE:`LSB_SOURCE] == `SOURCE_PWM_PIN);
assign period_end = pwm_sync & ~pwm_last;

// Field views of the stored word, shared by several decoders
assign slope_code  = user_configuration_one[`MSB_SLOPE:`LSB_SLOPE];
assign dither_code = user_configuration_one[`MSB_DITHER:`LSB_DITHER];
assign smooth_sel  = user_configuration_one[`BIT_SMOOTH];

// duty measurement
// Duty = high/period scaled to 16 bits; one rising edge per period. A divide
// per period is costly but periods are long, so a simple quotient is used.
always @(posedge CLK_SYS or negedge RESETN)
begin
    if (!RESETN)
    begin
        high_count   <= {DUTY_WIDTH{1'b0}};
        period_count <= {DUTY_WIDTH{1'b0}};
        duty_value   <= {DUTY_WIDTH{1'b0}};
    end
    // Counters idle unless source code 0 selects the pin; last duty is kept
    else if (!pin_source)
    begin
        high_count   <= {DUTY_WIDTH{1'b0}};
        period_count <= {DUTY_WIDTH{1'b0}};
    end
    // Latch the ratio of the period just ended and restart both counts
    else if (period_end)
    begin
        if (period_count != {DUTY_WIDTH{1'b0}})
            duty_value <= duty_ratio(high_count, period_count);
        high_count   <= {{(DUTY_WIDTH-1){1'b0}}, 1'b1};
        period_count <= {{(DUTY_WIDTH-1){1'b0}}, 1'b1};
    end
    // Both counters stop once the period count reaches full scale so a stuck pin cannot wrap
    else if (period_count != {DUTY_WIDTH{1'b1}})
    begin
        period_count <= period_count + {{(DUTY_WIDTH-1){1'b0}}, 1'b1};
        high_count   <= high_count + {{(DUTY_WIDTH-1){1'b0}}, pwm_sync};
    end
end

endmodule

// File: test/backlight_user_config_assertions.sv
// Assertions tying decoded outputs to the last configuration write
`timescale 1ns/1ns
module backlight_user_config_assertions
(
    input wire        CLK_SYS,
    input wire        RESETN,
    input wire [7:0]  REG_ADDR,
    input wire        REG_WRITE,
    input wire [15:0] REG_WDATA,
    input wire        PSEUDO_RANDOM_ENABLE,
    input wire [1:0]  SPREAD_MODULATION_RATE,
    input wire [1:0]  BOOST_OSCILLATOR_RANGE,
    input wire        BRIGHTNESS_FROM_REGISTER,
    input wire        SLOPE_ENABLE,
    input wire [2:0]  DITHER_BITS,
    input wire        SMOOTH_TRANSITION_ENABLE,
    input wire [1:0]  SMOOTH_FILTER_SHIFT
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);

    // Configuration write taken at this edge
    wire cfg_hit = REG_WRITE && (REG_ADDR == 8'h04);

    // A write not followed by another, so the outputs settle on its data
    sequence cfg_wr;
        cfg_hit;
    endsequence
    sequence lone_wr;
        cfg_wr ##1 !cfg_hit;
    endsequence

    a_pseudo_bit: assert property (lone_wr |=>
        PSEUDO_RANDOM_ENABLE == $past(REG_WDATA[14], 2))
        else $error("pseudo enable wrong");
    a_mod_rate: assert property (lone_wr |=>
        SPREAD_MODULATION_RATE == $past(REG_WDATA[13:12], 2))
        else $error("modulation rate wrong");
    a_spread_range: assert property (lone_wr |=>
        BOOST_OSCILLATOR_RANGE == $past(REG_WDATA[11:10], 2))
        else $error("spread range wrong");
    a_source_sel: assert property (lone_wr |=>
        BRIGHTNESS_FROM_REGISTER == ($past(REG_WDATA[9:8], 2) == 2'h2))
        else $error("brightness source wrong");
    a_slope_on: assert property (lone_wr |=>
        SLOPE_ENABLE == ($past(REG_WDATA[7:5], 2) != 3'h0))
        else $error("slope enable wrong");
    a_dither_depth: assert property (lone_wr |=>
        DITHER_BITS == ($past(REG_WDATA[4], 2) ? 3'h4 : $past(REG_WDATA[4:2], 2)))
        else $error("dither depth wrong");
    a_smooth_style: assert property (lone_wr |=>
        SMOOTH_TRANSITION_ENABLE == $past(REG_WDATA[1], 2))
        else $error("sloping style wrong");
    a_smooth_shift: assert property (lone_wr |=>
        SMOOTH_FILTER_SHIFT == ($past(REG_WDATA[1], 2) ? 2'h2 : 2'h0))
        else $error("smoothing shift wrong");
endmodule

bind backlight_user_config backlight_user_config_assertions checker_i
(
    .CLK_SYS                  (CLK_SYS),
    .RESETN                   (RESETN),
    .REG_ADDR                 (REG_ADDR),
    .REG_WRITE                (REG_WRITE),
    .REG_WDATA                (REG_WDATA),
    .PSEUDO_RANDOM_ENABLE     (PSEUDO_RANDOM_ENABLE),
    .SPREAD_MODULATION_RATE   (SPREAD_MODULATION_RATE),
    .BOOST_OSCILLATOR_RANGE   (BOOST_OSCILLATOR_RANGE),
    .BRIGHTNESS_FROM_REGISTER (BRIGHTNESS_FROM_REGISTER),
    .SLOPE_ENABLE             (SLOPE_ENABLE),
    .DITHER_BITS              (DITHER_BITS),
    .SMOOTH_TRANSITION_ENABLE (SMOOTH_TRANSITION_ENABLE),
    .SMOOTH_FILTER_SHIFT      (SMOOTH_FILTER_SHIFT)
);

// File: test/pwm_source.sv
// PWM pin source standing in for the external brightness signal
`timescale 1ns/1ns
module pwm_source
(
    input  wire       clk,
    input  wire [7:0] high,
    input  wire [7:0] period,
    output reg        pwm
);
    reg [7:0] count = 8'h00;

    // Free-running period counter; the pin is registered on the device clock edge
    always @(posedge clk)
    begin
        count <= (count + 8'h01 >= period) ? 8'h00 : count + 8'h01;
        pwm   <= (count < high);
    end
endmodule

// File: test/tb_backlight_user_config.sv
// Self-checking bench for the user configuration register
`timescale 1ns/1ns
module tb_backlight_user_config;
    reg         clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0;
    reg  [7:0]  addr = 8'h00;
    reg  [15:0] wdata = 16'h0000, w;
    wire        pwm, pre, frm, sen, smo;
    wire [15:0] rdata;
    wire [1:0]  rate, rng, shf;
    wire [2:0]  sdur, dith;
    wire [19:0] tms;
    integer     bad_count = 0, checks = 0, i;
    // Slope times in ms for codes 0 to 7, linear style
    localparam [79:0] MS = {10'h1F4, 10'h12C, 10'h0C8, 10'h064, 10'h032, 10'h002, 10'h001, 10'h000};

    backlight_user_config dut (.CLK_SYS(clk), .RESETN(rstn), .REG_ADDR(addr), .REG_WRITE(wr),
        .REG_READ(rd), .REG_WDATA(wdata), .REG_RDATA(rdata), .PWM_IN(pwm),
        .PSEUDO_RANDOM_ENABLE(pre), .SPREAD_MODULATION_RATE(rate), .BOOST_OSCILLATOR_RANGE(rng),
        .BRIGHTNESS_FROM_REGISTER(frm), .SLOPE_DURATION(sdur), .SLOPE_ENABLE(sen),
        .DITHER_BITS(dith), .SMOOTH_TRANSITION_ENABLE(smo), .SMOOTH_FILTER_SHIFT(shf),
        .SLOPE_TIME_MS(tms));
    pwm_source src (.clk(clk), .high(8'h04), .period(8'h10), .pwm(pwm));

    initial forever #2 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////
    // Compare, write and read tasks; waits are fixed by the hand-over timing
    task chk(input [19:0] got, input [19:0] exp);
    begin
        checks = checks + 1;
        if (got !== exp)
        begin
            bad_count = bad_count + 1;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    end
    endtask
    task wrt(input [7:0] a, input [15:0] d);
    begin
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        repeat (3) @(posedge clk);
    end
    endtask
    task rdc(input [7:0] a, input [15:0] e);
    begin
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        chk(rdata, e);
    end
    endtask
    task complete_run;
    begin
        if (bad_count == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Reset image, every slope and dither code, source codes 0 and 2, refused accesses, then pin duty
    initial
    begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        rdc(8'h04, 16'h08A3);
        chk(tms, 20'h00190);
        // all slope codes, linear for codes 0 to 3 and smooth for 4 to 7, reserved bits kept
        for (i = 0; i < 8; i = i + 1)
        begin
            w = {1'b0, i[0], i[1:0], i[1:0], (i[1] ? 2'h2 : 2'h0), i[2:0], i[2:0], i[2], 1'b1};
            wrt(8'h04, w);
            rdc(8'h04, w);
            chk(pre, i[0]);
            chk(rate, i[1:0]);
            chk(rng, i[1:0]);
            chk(frm, i[1]);
            chk(sdur, i[2:0]);
            chk(sen, i != 0);
            chk(dith, (i > 4) ? 4 : i);
            chk(smo, i[2]);
            chk(shf, i[2] ? 2'h2 : 2'h0);
            chk(tms, MS[i*10 +: 10] << i[2]);
        end
        wrt(8'h06, 16'hFFFF);
        rdc(8'h04, w);
        rdc(8'h06, 16'h0000);
        wrt(8'h04, 16'h08A3);
        repeat (60) @(posedge clk);
        rdc(8'h16, 16'h4000);
        complete_run;
    end
endmodule
